// ### sio_cfg_if.sv
// Purpose: I/O cycle carrier between host and configuration device
// Assumes: One cycle write or read strobe; read data in the next cycle
// Notes:   No clocking block
interface sio_cfg_if;
   logic [15:0] ioAddr;
   logic [7:0]  ioWdata;
   logic        ioWr;
   logic        ioRd;
   logic [7:0]  ioRdata;

   modport host (
      output ioAddr,
      output ioWdata,
      output ioWr,
      output ioRd,
      input  ioRdata
   );
   modport device (
      input  ioAddr,
      input  ioWdata,
      input  ioWr,
      input  ioRd,
      output ioRdata
   );
endinterface

// ### sio_gpio_device.sv
// Purpose: Configuration device holding the GPIO pin registers
// Assumes: Host keeps one-cycle strobes, never read and write together
// Notes:   Pins are three signals each; input pins pass two flops
//
// The strobed register port is this design's own decision.
module sio_gpio_device #(
   parameter int PIN_W = 8
) (
   // Clock and reset
   input  wire logic             mclk,
   input  wire logic             rst_b,
   // Host I/O cycles
   sio_cfg_if.device             io,
   // GPIO pins
   input  wire logic [PIN_W-1:0] pinIn,
   output logic      [PIN_W-1:0] pinOut,
   output logic      [PIN_W-1:0] pinOe,
   // Function enable seen by the board
   output logic                  gpioEnabled
);
   import sio_gpio_pkg::*;

   // Pin registers are one configuration byte wide
   if (PIN_W != DATA_W) begin : g_widthCheck
      $error("PIN_W must equal register width");
   end

   logic [7:0] pinSync1_r;
   logic [7:0] pinSync2_r;
   logic       keySeen_r,  keySeen_nxt;
   logic       unlocked_r, unlocked_nxt;
   logic [7:0] index_r,    index_nxt;
   logic [7:0] ldev_r,     ldev_nxt;
   logic [7:0] funcEn_r,   funcEn_nxt;
   logic [7:0] dir_r,      dir_nxt;
   logic [7:0] value_r,    value_nxt;
   logic [7:0] polarity_r, polarity_nxt;
   logic [7:0] rdata_r,    rdata_nxt;
   logic [7:0] pinOut_r,   pinOut_nxt;
   logic [7:0] pinOe_r,    pinOe_nxt;
   logic [7:0] regRead;
   logic       idxWr;
   logic       dataWr;
   logic       dataRd;
   logic       lockedWr;
   logic       selLdev;
   logic       selFuncEn;
   logic       selPinCtl;

   // Decoded port accesses of this cycle
   assign idxWr     = io.ioWr && io.ioAddr == PORT_INDEX;
   assign dataWr    = io.ioWr && io.ioAddr == PORT_DATA && unlocked_r;
   assign dataRd    = io.ioRd && io.ioAddr == PORT_DATA && unlocked_r;
   // Data port write while locked breaks a half key
   assign lockedWr  = io.ioWr && io.ioAddr == PORT_DATA && !unlocked_r;
   // Register selected by index and logical device
   assign selLdev   = index_r == IDX_LDEV_SEL;
   assign selFuncEn = ldev_r == LDEV_FUNC && index_r == IDX_FUNC_EN;
   assign selPinCtl = ldev_r == LDEV_PINCTL;

   // Register seen through the data port
   always_comb begin
      regRead = UNMAPPED_READ;
      if (index_r == IDX_LDEV_SEL) begin
         regRead = ldev_r;
      end else if (ldev_r == LDEV_FUNC && index_r == IDX_FUNC_EN) begin
         regRead = funcEn_r;
      end else if (ldev_r == LDEV_PINCTL) begin
         case (index_r)
            IDX_DIR:      regRead = dir_r;
            // Input bits show the synchronised pin through the inverter
            IDX_VALUE:    regRead = (dir_r & (pinSync2_r ^ polarity_r)) | (~dir_r & value_r);
            IDX_POLARITY: regRead = polarity_r;
            default:      regRead = UNMAPPED_READ;
         endcase
      end
   end

   // Key pair, lock and index register
   always_comb begin
      keySeen_nxt  = keySeen_r;
      unlocked_nxt = unlocked_r;
      index_nxt    = index_r;
      if (idxWr) begin
         if (!unlocked_r) begin
            // Any other write breaks the key pair
            keySeen_nxt  = io.ioWdata == KEY_ENTER && !keySeen_r;
            unlocked_nxt = io.ioWdata == KEY_ENTER && keySeen_r;
         end else if (io.ioWdata == KEY_EXIT) begin
            // Exit key is never stored as index
            unlocked_nxt = 1'b0;
            keySeen_nxt  = 1'b0;
         end else begin
            index_nxt = io.ioWdata;
         end
      end else if (lockedWr) begin
         keySeen_nxt = 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         keySeen_r  <= 1'b0;
         unlocked_r <= 1'b0;
         index_r    <= 8'h00;
      end else begin
         keySeen_r  <= keySeen_nxt;
         unlocked_r <= unlocked_nxt;
         index_r    <= index_nxt;
      end
   end

   // Configuration registers, written only while unlocked
   always_comb begin
      ldev_nxt     = ldev_r;
      funcEn_nxt   = funcEn_r;
      dir_nxt      = dir_r;
      value_nxt    = value_r;
      polarity_nxt = polarity_r;
      if (dataWr) begin
         // Device select is seen from every logical device
         if (selLdev) begin
            ldev_nxt = io.ioWdata;
         end else if (selFuncEn) begin
            funcEn_nxt = io.ioWdata;
         end else if (selPinCtl) begin
            case (index_r)
               IDX_DIR:      dir_nxt = io.ioWdata;
               // Input bits keep their old value
               IDX_VALUE:    value_nxt = (~dir_r & io.ioWdata) | (dir_r & value_r);
               IDX_POLARITY: polarity_nxt = io.ioWdata;
               default:      value_nxt = value_r;
            endcase
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         ldev_r     <= RST_LDEV;
         funcEn_r   <= RST_FUNC_EN;
         dir_r      <= RST_DIR;
         value_r    <= RST_VALUE;
         polarity_r <= RST_POLARITY;
      end else begin
         ldev_r     <= ldev_nxt;
         funcEn_r   <= funcEn_nxt;
         dir_r      <= dir_nxt;
         value_r    <= value_nxt;
         polarity_r <= polarity_nxt;
      end
   end

   // Read answer stands one cycle, otherwise all ones
   always_comb begin
      rdata_nxt = UNMAPPED_READ;
      if (dataRd) begin
         rdata_nxt = regRead;
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         rdata_r <= UNMAPPED_READ;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   // Pin drive follows registers of the previous cycle
   always_comb begin
      pinOut_nxt = value_r ^ polarity_r;
      pinOe_nxt  = funcEn_r[FUNC_EN_BIT] ? ~dir_r : 8'h00;
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         pinOut_r <= 8'h00;
         pinOe_r  <= 8'h00;
      end else begin
         pinOut_r <= pinOut_nxt;
         pinOe_r  <= pinOe_nxt;
      end
   end

   // Two-flop synchroniser for the asynchronous pins
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         pinSync1_r <= 8'h00;
         pinSync2_r <= 8'h00;
      end else begin
         pinSync1_r <= pinIn;
         pinSync2_r <= pinSync1_r;
      end
   end

   assign io.ioRdata  = rdata_r;
   assign pinOut      = pinOut_r;
   assign pinOe       = pinOe_r;
   assign gpioEnabled = funcEn_r[FUNC_EN_BIT];
endmodule // sio_gpio_device

// ### sio_gpio_host.sv
// Purpose: Host end issuing configuration I/O cycles on software order
// Assumes: Software port: address, wdata, write and read strobes
// Notes:   Exit is one I/O cycle; enter, write and read commands are two each
module sio_gpio_host (
   // Clock and reset
   input  wire logic       mclk,
   input  wire logic       rst_b,
   // Software register port
   input  wire logic [3:0] swAddr,
   input  wire logic [7:0] swWdata,
   input  wire logic       swWr,
   input  wire logic       swRd,
   output logic      [7:0] swRdata,
   // Configuration I/O cycles
   sio_cfg_if.host         io
);
   import sio_gpio_pkg::*;

   typedef enum logic [2:0] {S_IDLE, S_KEY2, S_DATA, S_RDWAIT} hstate_e;

   hstate_e     state_r,  state_nxt;
   logic [7:0]  idx_r,    idx_nxt;
   logic [7:0]  data_r,   data_nxt;
   logic [7:0]  rdReg_r,  rdReg_nxt;
   logic [1:0]  cmd_r,    cmd_nxt;
   logic [15:0] addr_r,   addr_nxt;
   logic [7:0]  wdata_r,  wdata_nxt;
   logic        wr_r,     wr_nxt;
   logic        rd_r,     rd_nxt;
   logic [7:0]  swRd_r,   swRd_nxt;
   logic        busy;

   assign busy = state_r != S_IDLE;

   always_comb begin
      state_nxt = state_r;
      idx_nxt   = idx_r;
      data_nxt  = data_r;
      rdReg_nxt = rdReg_r;
      cmd_nxt   = cmd_r;
      addr_nxt  = addr_r;
      wdata_nxt = wdata_r;
      wr_nxt    = 1'b0;
      rd_nxt    = 1'b0;
      swRd_nxt  = 8'h00;
      if (swRd) begin
         case (swAddr)
            HREG_IDX:    swRd_nxt = idx_r;
            HREG_DATA:   swRd_nxt = data_r;
            HREG_CMD:    swRd_nxt = {6'h00, cmd_r};
            HREG_STATUS: swRd_nxt = {7'h00, busy};
            HREG_RDATA:  swRd_nxt = rdReg_r;
            default:     swRd_nxt = 8'h00;
         endcase
      end
      if (swWr && swAddr == HREG_IDX) idx_nxt = swWdata;
      if (swWr && swAddr == HREG_DATA) data_nxt = swWdata;
      case (state_r)
         S_IDLE: begin
            if (swWr && swAddr == HREG_CMD) begin
               cmd_nxt  = swWdata[1:0];
               addr_nxt = PORT_INDEX;
               wr_nxt   = 1'b1;
               case (swWdata[1:0])
                  CMD_ENTER: begin
                     wdata_nxt = KEY_ENTER;
                     state_nxt = S_KEY2;
                  end
                  CMD_EXIT: wdata_nxt = KEY_EXIT;
                  default: begin
                     wdata_nxt = idx_r;
                     state_nxt = S_DATA;
                  end
               endcase
            end
         end
         S_KEY2: begin
            wr_nxt    = 1'b1;
            state_nxt = S_IDLE;
         end
         S_DATA: begin
            addr_nxt  = PORT_DATA;
            wdata_nxt = data_r;
            if (cmd_r == CMD_READ) begin
               rd_nxt    = 1'b1;
               state_nxt = S_RDWAIT;
            end else begin
               wr_nxt    = 1'b1;
               state_nxt = S_IDLE;
            end
         end
         S_RDWAIT: begin
            if (!rd_r) begin
               rdReg_nxt = io.ioRdata;
               state_nxt = S_IDLE;
            end
         end
         default: state_nxt = S_IDLE;
      endcase
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         state_r <= S_IDLE;
         idx_r   <= 8'h00;
         data_r  <= 8'h00;
         rdReg_r <= 8'h00;
         cmd_r   <= 2'h0;
         addr_r  <= 16'h0000;
         wdata_r <= 8'h00;
         wr_r    <= 1'b0;
         rd_r    <= 1'b0;
         swRd_r  <= 8'h00;
      end else begin
         state_r <= state_nxt;
         idx_r   <= idx_nxt;
         data_r  <= data_nxt;
         rdReg_r <= rdReg_nxt;
         cmd_r   <= cmd_nxt;
         addr_r  <= addr_nxt;
         wdata_r <= wdata_nxt;
         wr_r    <= wr_nxt;
         rd_r    <= rd_nxt;
         swRd_r  <= swRd_nxt;
      end
   end

   assign io.ioAddr  = addr_r;
   assign io.ioWdata = wdata_r;
   assign io.ioWr    = wr_r;
   assign io.ioRd    = rd_r;
   assign swRdata    = swRd_r;
endmodule // sio_gpio_host

// ### sio_gpio_pkg.sv
// Purpose: Shared constants for the index/data configuration port GPIO
// Assumes: 8-bit I/O cycles, one clock mclk at 125 MHz
// Notes:   Used by both ends, the protocol checks and the bench
package sio_gpio_pkg;
   localparam int          DATA_W          = 8;
   localparam int          ADDR_W          = 16;
   localparam logic [15:0] PORT_INDEX      = 16'h002E;
   localparam logic [15:0] PORT_DATA       = 16'h002F;
   localparam logic [7:0]  KEY_ENTER       = 8'h87;
   localparam logic [7:0]  KEY_EXIT        = 8'hAA;
   localparam logic [7:0]  IDX_LDEV_SEL    = 8'h07;
   localparam logic [7:0]  LDEV_PINCTL     = 8'h07;
   localparam logic [7:0]  LDEV_FUNC       = 8'h09;
   localparam logic [7:0]  IDX_FUNC_EN     = 8'h30;
   localparam logic [7:0]  IDX_DIR         = 8'hE0;
   localparam logic [7:0]  IDX_VALUE       = 8'hE1;
   localparam logic [7:0]  IDX_POLARITY    = 8'hE2;
   localparam int          FUNC_EN_BIT     = 7;
   localparam logic [7:0]  RST_FUNC_EN     = 8'h00;
   localparam logic [7:0]  RST_DIR         = 8'hFF;
   localparam logic [7:0]  RST_VALUE       = 8'h00;
   localparam logic [7:0]  RST_POLARITY    = 8'h00;
   localparam logic [7:0]  RST_LDEV        = 8'h00;
   localparam logic [7:0]  UNMAPPED_READ   = 8'hFF;
   // Host command codes in its own command register
   localparam logic [1:0]  CMD_ENTER       = 2'h0;
   localparam logic [1:0]  CMD_EXIT        = 2'h1;
   localparam logic [1:0]  CMD_WRITE       = 2'h2;
   localparam logic [1:0]  CMD_READ        = 2'h3;
   // Host software register offsets
   localparam logic [3:0]  HREG_IDX        = 4'h0;
   localparam logic [3:0]  HREG_DATA       = 4'h1;
   localparam logic [3:0]  HREG_CMD        = 4'h2;
   localparam logic [3:0]  HREG_STATUS     = 4'h3;
   localparam logic [3:0]  HREG_RDATA      = 4'h4;
   localparam int          STATUS_BUSY_BIT = 0;
endpackage

// ### sio_gpio_props.sv
// Purpose: Protocol checks on the configuration I/O link
// Assumes: One clock mclk, rst_b async active low
// Notes:   Watches the interface signals only
module sio_gpio_props (
   // Clock and reset
   input wire logic        mclk,
   input wire logic        rst_b,
   // Link signals
   input wire logic [15:0] ioAddr,
   input wire logic [7:0]  ioWdata,
   input wire logic        ioWr,
   input wire logic        ioRd,
   input wire logic [7:0]  ioRdata
);
   timeunit 1ns;
   timeprecision 1ps;
   import sio_gpio_pkg::*;
   wire logic idxWr = ioWr && ioAddr == PORT_INDEX;
   wire logic keyWr = idxWr && ioWdata == KEY_ENTER;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);
   sequence enterPair;
      keyWr ##1 keyWr;
   endsequence
   chk_strobe_excl: assert property (!(ioWr && ioRd))
      else $error("read and write strobes together");
   chk_read_port: assert property (ioRd |-> ioAddr == PORT_DATA)
      else $error("read not at data port");
   chk_read_order: assert property (ioRd |-> $past(idxWr))
      else $error("read without index write before it");
   chk_data_order: assert property (ioWr && ioAddr == PORT_DATA |-> $past(idxWr))
      else $error("data write without index write before it");
   chk_key_pair: assert property (keyWr && !$past(keyWr) |-> enterPair)
      else $error("entry key not written twice");
   chk_enter_quiet: assert property (enterPair |=> !ioWr && !ioRd)
      else $error("traffic right after entry keys");
   chk_exit_quiet: assert property (idxWr && ioWdata == KEY_EXIT |=> !ioWr && !ioRd)
      else $error("traffic right after exit key");
   chk_rdata_idle: assert property (!$past(ioRd) |-> ioRdata == UNMAPPED_READ)
      else $error("read data driven outside read answer");
endmodule // sio_gpio_props

// ### tb_superio_gpio_config_port.sv
// Purpose: Self-checking bench for host and device ends
// Assumes: mclk 125 MHz, rst_b held 16 cycles
// Notes:   Reference model in plain variables
module tb_superio_gpio_config_port;
   timeunit 1ns;
   timeprecision 1ps;
   import sio_gpio_pkg::*;
   logic       mclk = 1'b0, rst_b = 1'b0, swWr = 1'b0, swRd = 1'b0, gpioEnabled;
   logic [3:0] swAddr = 4'h0;
   logic [7:0] swWdata = 8'h00, pinIn = 8'h00, swRdata, pinOut, pinOe, r, e;
   logic [7:0] ldev, fen, dir, val, pol;
   int         errCount = 0, checksDone = 0, lk = 1;
   sio_cfg_if link();
   sio_gpio_device sio_gpio_device_i (.mclk(mclk), .rst_b(rst_b), .io(link), .pinIn(pinIn),
      .pinOut(pinOut), .pinOe(pinOe), .gpioEnabled(gpioEnabled));
   sio_gpio_host sio_gpio_host_i (.mclk(mclk), .rst_b(rst_b), .swAddr(swAddr), .swWdata(swWdata),
      .swWr(swWr), .swRd(swRd), .swRdata(swRdata), .io(link));
   sio_gpio_props sio_gpio_props_i (.mclk(mclk), .rst_b(rst_b), .ioAddr(link.ioAddr),
      .ioWdata(link.ioWdata), .ioWr(link.ioWr), .ioRd(link.ioRd), .ioRdata(link.ioRdata));
   task automatic stopTest();
      $display("Checks: %0d, mismatches: %0d", checksDone, errCount);
      if (errCount == 0 && checksDone > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic chk(string n, logic [7:0] s, logic [7:0] x);
      checksDone++;
      if (s !== x) begin
         errCount++;
         $display("[ERR] %s exp %h seen %h", n, x, s);
      end
   endtask
   task automatic swW(logic [3:0] a, logic [7:0] d);
      @(posedge mclk);
      swAddr  <= a;
      swWdata <= d;
      swWr    <= 1'b1;
      @(posedge mclk);
      swWr <= 1'b0;
   endtask
   task automatic swR(logic [3:0] a);
      @(posedge mclk);
      swAddr <= a;
      swRd   <= 1'b1;
      @(posedge mclk);
      swRd <= 1'b0;
      #1 r = swRdata;
   endtask
   task automatic cmd(logic [1:0] c);
      swW(HREG_CMD, {6'h00, c});
      r = 8'h01;
      for (int i = 0; i < 30 && r[STATUS_BUSY_BIT] !== 1'b0; i++)
         swR(HREG_STATUS);
      chk("busy", {7'h00, r[STATUS_BUSY_BIT]}, 8'h00);
   endtask
   // Model follows every write accepted while unlocked
   task automatic cw(logic [7:0] i, logic [7:0] d);
      swW(HREG_IDX, i);
      swW(HREG_DATA, d);
      swR(HREG_DATA);
      chk("data reg", r, d);
      cmd(CMD_WRITE);
      if (lk == 0) begin
         if (i == IDX_LDEV_SEL) ldev = d;
         else if (ldev == LDEV_FUNC && i == IDX_FUNC_EN) fen = d;
         else if (ldev == LDEV_PINCTL && i == IDX_DIR) dir = d;
         else if (ldev == LDEV_PINCTL && i == IDX_VALUE) val = (val & dir) | (d & ~dir);
         else if (ldev == LDEV_PINCTL && i == IDX_POLARITY) pol = d;
      end
   endtask
   task automatic cr(logic [7:0] i);
      swW(HREG_IDX, i);
      cmd(CMD_READ);
      swR(HREG_IDX);
      chk("index reg", r, i);
      swR(HREG_CMD);
      chk("cmd reg", r, {6'h00, CMD_READ});
      swR(HREG_RDATA);
      e = UNMAPPED_READ;
      if (lk == 0) begin
         if (i == IDX_LDEV_SEL) e = ldev;
         else if (ldev == LDEV_FUNC && i == IDX_FUNC_EN) e = fen;
         else if (ldev == LDEV_PINCTL && i == IDX_DIR) e = dir;
         else if (ldev == LDEV_PINCTL && i == IDX_VALUE) e = (dir & (pinIn ^ pol)) | (~dir & val);
         else if (ldev == LDEV_PINCTL && i == IDX_POLARITY) e = pol;
      end
      chk("cfg read", r, e);
   endtask
   initial begin
      forever #4 mclk = ~mclk;
   end
   initial begin
      #40000;
      errCount++;
      stopTest();
   end
   initial begin
      void'($urandom(32'h05ACB903));
      {ldev, fen, dir, val, pol} = {RST_LDEV, RST_FUNC_EN, RST_DIR, RST_VALUE, RST_POLARITY};
      repeat (16) @(posedge mclk);
      chk("oe in reset", pinOe, 8'h00);
      chk("rdata in reset", link.ioRdata, UNMAPPED_READ);
      rst_b <= 1'b1;
      cw(IDX_DIR, 8'h00);
      cr(IDX_DIR);
      cmd(CMD_ENTER);
      lk = 0;
      cw(IDX_LDEV_SEL, LDEV_FUNC);
      cr(IDX_FUNC_EN);
      cw(IDX_FUNC_EN, r | 8'h80);
      cr(IDX_FUNC_EN);
      chk("enable", {7'h00, gpioEnabled}, {7'h00, fen[FUNC_EN_BIT]});
      cw(IDX_LDEV_SEL, LDEV_PINCTL);
      cr(IDX_LDEV_SEL);
      cr(IDX_DIR);
      cr(8'hE5);
      repeat (8) begin
         @(posedge mclk) pinIn <= 8'($urandom);
         cw(IDX_DIR, 8'($urandom));
         cw(IDX_POLARITY, 8'($urandom));
         cw(IDX_VALUE, 8'($urandom));
         cr(IDX_VALUE);
         chk("pin enable", pinOe, ~dir);
         chk("pin drive", pinOut & ~dir, (val ^ pol) & ~dir);
      end
      cmd(CMD_EXIT);
      lk = 1;
      cr(IDX_POLARITY);
      cw(IDX_DIR, 8'h55);
      cmd(CMD_ENTER);
      lk = 0;
      cw(IDX_LDEV_SEL, LDEV_PINCTL);
      cr(IDX_DIR);
      // Mid-run reset brings back lock and reset values
      @(posedge mclk) rst_b <= 1'b0;
      repeat (4) @(posedge mclk);
      chk("oe after reset", pinOe, 8'h00);
      chk("enable after reset", {7'h00, gpioEnabled}, {7'h00, RST_FUNC_EN[FUNC_EN_BIT]});
      rst_b <= 1'b1;
      {ldev, fen, dir, val, pol} = {RST_LDEV, RST_FUNC_EN, RST_DIR, RST_VALUE, RST_POLARITY};
      lk = 1;
      cr(IDX_LDEV_SEL);
      cmd(CMD_ENTER);
      lk = 0;
      cw(IDX_LDEV_SEL, LDEV_PINCTL);
      cr(IDX_DIR);
      cr(IDX_POLARITY);
      stopTest();
   end
endmodule // tb_superio_gpio_config_port
